// ==== pkg/i2cdw_regs.svh ====
// Constants of the two-wire DAC write slave: address, pointer and reset values.
`ifndef I2CDW_REGS_SVH
`define I2CDW_REGS_SVH

// Fixed upper five bits of the seven-bit slave address.
`define I2CDW_ADDR_FIXED    5'h15
// Read/write flag value that the slave accepts (write only).
`define I2CDW_RW_WRITE      1'h0
// Pointer byte value that selects auto-increment burst mode.
`define I2CDW_BURST_PTR     8'hFF
// Channel pointer value on reset and at the start of a burst.
`define I2CDW_CHANNEL_RST   8'h00
// Data bits per byte before the acknowledge clock.
`define I2CDW_BYTE_BITS     4'h8
// Default depth of the received word FIFO.
`define I2CDW_FIFO_DEPTH    32

`endif

// ==== pkg/i2cdw_pkg.sv ====
// Types shared by the two-wire DAC write slave and its word FIFO.
package i2cdw_pkg;

    // Receive phase, Gray coded along idle, receive, acknowledge.
    typedef enum logic [2:0] {
        I2CDW_IDLE   = 3'h0,
        I2CDW_RECV   = 3'h1,
        I2CDW_ACK    = 3'h3,
        I2CDW_IGNORE = 3'h2
    } i2cdw_state_t;

    // Meaning of the byte now being shifted in, Gray coded in byte order.
    typedef enum logic [1:0] {
        I2CDW_ROLE_ADDR = 2'h0,
        I2CDW_ROLE_PTR  = 2'h1,
        I2CDW_ROLE_HI   = 2'h3,
        I2CDW_ROLE_LO   = 2'h2
    } i2cdw_role_t;

    // One completed channel write handed to the DAC core.
    typedef struct packed {
        logic [7:0]  channel;
        logic        burst;
        logic        toggle_ok;
        logic [1:0]  reg_select;
        logic [13:0] value;
    } i2cdw_word_t;

endpackage

// ==== hw/i2cdw_fifo.sv ====
// Word FIFO with valid/ready on both sides and a registered read port.
`timescale 1ns/1ps
`include "i2cdw_regs.svh"

module i2cdw_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = `I2CDW_FIFO_DEPTH,
    localparam int AW   = $clog2(DEPTH)
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic             push;
    logic             load;

    // Full is honest: the writer is refused once every slot is taken.
    assign in_ready = (count != FULL_COUNT);
    assign push     = in_valid & in_ready;
    // The output register refills whenever it is empty or being drained.
    assign load     = (count != '0) & (~out_valid | out_ready);

    // Pointer, count and output stage next values.
    always_comb
    begin
        next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr    = load ? rd_ptr + 1'b1 : rd_ptr;
        next_count     = count;
        next_out_valid = out_valid;
        next_out_data  = out_data;
        if (push && !load)
        begin
            next_count = count + 1'b1;
        end
        else if (load && !push)
        begin
            next_count = count - 1'b1;
        end
        if (load)
        begin
            next_out_valid = 1'b1;
            next_out_data  = mem[rd_ptr];
        end
        else if (out_ready)
        begin
            next_out_valid = 1'b0;
        end
    end

    // Storage has no reset; only the pointers and flags need a known value.
    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Registers of the pointers and output stage.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end
        else
        begin
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            out_valid <= next_out_valid;
            out_data  <= next_out_data;
        end
    end

endmodule

// ==== hw/i2cdw_slave.sv ====
// Receive-only two-wire slave of a multichannel DAC, feeding a word FIFO.
`timescale 1ns/1ps
`include "i2cdw_regs.svh"

module i2cdw_slave #(
    parameter int FIFO_DEPTH = `I2CDW_FIFO_DEPTH
) (
    input  wire logic               sys_clk,
    input  wire logic               rst_b,
    input  wire logic               scl_in,
    input  wire logic               sda_in,
    output logic                    sda_out,
    output logic                    sda_oe,
    input  wire logic               addr_strap_hi,
    input  wire logic               addr_strap_lo,
    output logic                    bus_active,
    output logic                    wr_valid,
    input  wire logic               wr_ready,
    output i2cdw_pkg::i2cdw_word_t  wr_data
);

    // Pin synchronisers and the previous synchronised level for edges.
    logic       scl_meta;
    logic       scl_sync;
    logic       scl_prev;
    logic       sda_meta;
    logic       sda_sync;
    logic       sda_prev;
    logic [1:0] strap_meta;
    logic [1:0] strap_sync;
    logic       next_scl_meta;
    logic       next_scl_sync;
    logic       next_scl_prev;
    logic       next_sda_meta;
    logic       next_sda_sync;
    logic       next_sda_prev;
    logic [1:0] next_strap_meta;
    logic [1:0] next_strap_sync;

    // Bus events decoded from the synchronised lines.
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    // Receiver state.
    i2cdw_pkg::i2cdw_state_t state;
    i2cdw_pkg::i2cdw_state_t next_state;
    i2cdw_pkg::i2cdw_role_t  role;
    i2cdw_pkg::i2cdw_role_t  next_role;
    logic [3:0]              bit_cnt;
    logic [3:0]              next_bit_cnt;
    logic [7:0]              shreg;
    logic [7:0]              next_shreg;
    logic [7:0]              hi_byte;
    logic [7:0]              next_hi_byte;
    logic [7:0]              channel;
    logic [7:0]              next_channel;
    logic                    burst;
    logic                    next_burst;
    logic                    next_sda_oe;

    // Byte decisions and the FIFO write side.
    logic                    byte_done;
    logic                    addr_match;
    logic                    push;
    logic                    push_ready;
    i2cdw_pkg::i2cdw_word_t  push_word;

    // Every pin passes two flops before any logic; the third flop of SCL and SDA only
    // remembers the last synchronised level so edges can be found.
    always_comb
    begin
        next_scl_meta   = scl_in;
        next_scl_sync   = scl_meta;
        next_scl_prev   = scl_sync;
        next_sda_meta   = sda_in;
        next_sda_sync   = sda_meta;
        next_sda_prev   = sda_sync;
        next_strap_meta = {addr_strap_hi, addr_strap_lo};
        next_strap_sync = strap_meta;
    end

    // Lines idle high, so the SCL and SDA synchronisers reset to one; the strap ones reset to zero.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_meta   <= 1'b1;
            scl_sync   <= 1'b1;
            scl_prev   <= 1'b1;
            sda_meta   <= 1'b1;
            sda_sync   <= 1'b1;
            sda_prev   <= 1'b1;
            strap_meta <= 2'h0;
            strap_sync <= 2'h0;
        end
        else
        begin
            scl_meta   <= next_scl_meta;
            scl_sync   <= next_scl_sync;
            scl_prev   <= next_scl_prev;
            sda_meta   <= next_sda_meta;
            sda_sync   <= next_sda_sync;
            sda_prev   <= next_sda_prev;
            strap_meta <= next_strap_meta;
            strap_sync <= next_strap_sync;
        end
    end

    // Clock edges and the two SDA-while-SCL-high control events.  Both
    // SCL samples must be high so a clock edge is never read as control.
    assign scl_rise   = scl_sync & ~scl_prev;
    assign scl_fall   = ~scl_sync & scl_prev;
    assign start_cond = scl_sync & scl_prev & sda_prev & ~sda_sync;
    assign stop_cond  = scl_sync & scl_prev & ~sda_prev & sda_sync;

    // The eighth bit is in and SCL has fallen into the ninth period.
    assign byte_done  = (state == i2cdw_pkg::I2CDW_RECV) && scl_fall
                        && (bit_cnt == `I2CDW_BYTE_BITS);

    // Address compare; straps are read live so a board change takes effect
    // at the next address byte.
    assign addr_match = (shreg[7:3] == `I2CDW_ADDR_FIXED)
                        && (shreg[2:1] == strap_sync)
                        && (shreg[0] == `I2CDW_RW_WRITE);

    // Word assembly: first data byte is the upper half of the word.
    always_comb
    begin
        push_word.channel    = channel;
        push_word.burst      = burst;
        push_word.toggle_ok  = ~burst;
        push_word.reg_select = hi_byte[7:6];
        push_word.value      = {hi_byte[5:0], shreg};
    end

    // Receiver next values.  A start wins over everything, then a stop,
    // then the bit and acknowledge sequencing of the current phase.
    always_comb
    begin
        next_state   = state;
        next_role    = role;
        next_bit_cnt = bit_cnt;
        next_shreg   = shreg;
        next_hi_byte = hi_byte;
        next_channel = channel;
        next_burst   = burst;
        next_sda_oe  = sda_oe;
        push         = 1'b0;
        if (start_cond)
        begin
            // A repeated start needs no pass through idle.
            next_state   = i2cdw_pkg::I2CDW_RECV;
            next_role    = i2cdw_pkg::I2CDW_ROLE_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe  = 1'b0;
            next_burst   = 1'b0;
        end
        else if (stop_cond)
        begin
            next_state  = i2cdw_pkg::I2CDW_IDLE;
            next_sda_oe = 1'b0;
            next_burst  = 1'b0;
        end
        else
        begin
            case (state)
                i2cdw_pkg::I2CDW_RECV:
                begin
                    if (scl_rise && (bit_cnt != `I2CDW_BYTE_BITS))
                    begin
                        // Sample on the rising edge, most significant first.
                        next_shreg   = {shreg[6:0], sda_sync};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        case (role)
                            i2cdw_pkg::I2CDW_ROLE_ADDR:
                            begin
                                if (addr_match)
                                begin
                                    next_state  = i2cdw_pkg::I2CDW_ACK;
                                    next_sda_oe = 1'b1;
                                    next_role   = i2cdw_pkg::I2CDW_ROLE_PTR;
                                end
                                else
                                begin
                                    next_state = i2cdw_pkg::I2CDW_IGNORE;
                                end
                            end
                            i2cdw_pkg::I2CDW_ROLE_PTR:
                            begin
                                next_state  = i2cdw_pkg::I2CDW_ACK;
                                next_sda_oe = 1'b1;
                                next_role   = i2cdw_pkg::I2CDW_ROLE_HI;
                                if (shreg == `I2CDW_BURST_PTR)
                                begin
                                    next_burst   = 1'b1;
                                    next_channel = `I2CDW_CHANNEL_RST;
                                end
                                else
                                begin
                                    next_burst   = 1'b0;
                                    next_channel = shreg;
                                end
                            end
                            i2cdw_pkg::I2CDW_ROLE_HI:
                            begin
                                next_state   = i2cdw_pkg::I2CDW_ACK;
                                next_sda_oe  = 1'b1;
                                next_hi_byte = shreg;
                                next_role    = i2cdw_pkg::I2CDW_ROLE_LO;
                            end
                            i2cdw_pkg::I2CDW_ROLE_LO:
                            begin
                                // A full FIFO refuses the word with a missing
                                // acknowledge, so the master repeats it.
                                if (push_ready)
                                begin
                                    push        = 1'b1;
                                    next_state  = i2cdw_pkg::I2CDW_ACK;
                                    next_sda_oe = 1'b1;
                                    if (burst)
                                    begin
                                        next_channel = channel + 8'h01;
                                        next_role    = i2cdw_pkg::I2CDW_ROLE_HI;
                                    end
                                    else
                                    begin
                                        next_role = i2cdw_pkg::I2CDW_ROLE_PTR;
                                    end
                                end
                                else
                                begin
                                    next_state = i2cdw_pkg::I2CDW_IGNORE;
                                end
                            end
                            default:
                            begin
                                next_state = i2cdw_pkg::I2CDW_IGNORE;
                            end
                        endcase
                    end
                end
                i2cdw_pkg::I2CDW_ACK:
                begin
                    // Hold SDA low until SCL falls at the end of the ninth clock.
                    if (scl_fall)
                    begin
                        next_sda_oe  = 1'b0;
                        next_state   = i2cdw_pkg::I2CDW_RECV;
                        next_bit_cnt = 4'h0;
                    end
                end
                i2cdw_pkg::I2CDW_IDLE,
                i2cdw_pkg::I2CDW_IGNORE:
                begin
                    // Only a start condition leaves idle; a start or a stop leaves ignore.
                    next_sda_oe = 1'b0;
                end
                default:
                begin
                    next_state  = i2cdw_pkg::I2CDW_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    // Receiver registers.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state   <= i2cdw_pkg::I2CDW_IDLE;
            role    <= i2cdw_pkg::I2CDW_ROLE_ADDR;
            bit_cnt <= 4'h0;
            shreg   <= 8'h00;
            hi_byte <= 8'h00;
            channel <= `I2CDW_CHANNEL_RST;
            burst   <= 1'b0;
            sda_oe  <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            role    <= next_role;
            bit_cnt <= next_bit_cnt;
            shreg   <= next_shreg;
            hi_byte <= next_hi_byte;
            channel <= next_channel;
            burst   <= next_burst;
            sda_oe  <= next_sda_oe;
        end
    end

    // Open-drain data line: the slave only ever pulls low.  There is no
    // clock output at all, the master alone drives SCL.
    assign sda_out    = 1'b0;
    assign bus_active = (state != i2cdw_pkg::I2CDW_IDLE);

    // Completed writes wait here for the DAC core.
    i2cdw_fifo #(
        .WIDTH ($bits(i2cdw_pkg::i2cdw_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .in_valid  (push),
        .in_ready  (push_ready),
        .in_data   (push_word),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (wr_data)
    );

endmodule

// ==== dv/i2cdw_slave_props.sv ====
// Concurrent checks on the ports of the two-wire DAC write slave.
`timescale 1ns/1ps

module i2cdw_slave_props #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic                   sys_clk,
    input wire logic                   rst_b,
    input wire logic                   scl_in,
    input wire logic                   sda_in,
    input wire logic                   sda_out,
    input wire logic                   sda_oe,
    input wire logic                   addr_strap_hi,
    input wire logic                   addr_strap_lo,
    input wire logic                   bus_active,
    input wire logic                   wr_valid,
    input wire logic                   wr_ready,
    input wire i2cdw_pkg::i2cdw_word_t wr_data
);
    // All checks share the system clock and rest while reset is held.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    // The data pin is open drain, so the slave may only ever pull it low.
    a_sda_low_only: assert property (sda_out == 1'h0)
        else $error("sda_out not low");
    a_ack_in_frame: assert property (sda_oe |-> bus_active)
        else $error("acknowledge outside a transfer");

    // Start and stop are seen within the synchroniser delay.
    a_start_seen: assert property ($fell(sda_in) && scl_in |-> ##[1:5] bus_active)
        else $error("start not detected");
    a_stop_seen: assert property ($rose(sda_in) && scl_in |-> ##[1:5] !bus_active)
        else $error("stop not detected");

    // The acknowledge moves only while SCL is low and covers the whole ninth high phase.
    a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda_oe moved while scl high");
    a_ack_length: assert property ($rose(sda_oe) |-> sda_oe[*8] ##[1:8] !sda_oe)
        else $error("acknowledge length wrong");

    // A word appears only behind an acknowledged byte and waits intact for the consumer.
    a_word_acked: assert property ($rose(wr_valid) |-> sda_oe)
        else $error("word without acknowledge");
    a_word_holds: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
        else $error("word changed while stalled");
    a_toggle_burst: assert property (wr_valid |-> wr_data.toggle_ok == !wr_data.burst)
        else $error("toggle flag wrong for burst");
endmodule

bind i2cdw_slave i2cdw_slave_props #(.FIFO_DEPTH(FIFO_DEPTH)) i_i2cdw_slave_props (
    .sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_hi(addr_strap_hi),
    .addr_strap_lo(addr_strap_lo), .bus_active(bus_active), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data)
);

// ==== dv/i2cdw_master.sv ====
// Behavioural two-wire bus master that clocks SCL and pulls SDA low.
`timescale 1ns/1ps

module i2cdw_master (
    output logic     scl,
    output logic     sda_low,
    input wire logic sda
);
    // Quarter of the 48 ns SCL period; SCL stands still high between frames.
    localparam time Q = 12;

    // The bus starts idle with both lines released.
    initial
    begin
        scl = 1'h1;
        sda_low = 1'h0;
    end

    // Works from idle and as a repeated start from SCL low.
    task automatic send_start();
        sda_low = 1'h0;
        #Q;
        scl = 1'h1;
        #Q;
        sda_low = 1'h1;
        #Q;
        scl = 1'h0;
        #Q;
    endtask

    // SDA rises while SCL is high, then the bus is left released.
    task automatic send_stop();
        sda_low = 1'h1;
        #Q;
        scl = 1'h1;
        #Q;
        sda_low = 1'h0;
        #Q;
    endtask

    // Data changes only in the low phase; the ack is sampled mid ninth high phase.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sda_low = !b[i];
            #Q;
            scl = 1'h1;
            #(2 * Q);
            scl = 1'h0;
            #Q;
        end
        sda_low = 1'h0;
        #Q;
        scl = 1'h1;
        #Q;
        ack = (sda === 1'h0);
        #Q;
        scl = 1'h0;
        #Q;
    endtask
endmodule

// ==== dv/tb_i2cdw_slave.sv ====
// Self-checking bench of the two-wire DAC write slave and its word FIFO.
`timescale 1ns/1ps
`include "i2cdw_regs.svh"

module tb_i2cdw_slave;
    localparam int DEPTH = 4;

    logic                   sys_clk;
    logic                   rst_b;
    logic                   scl;
    logic                   m_low;
    logic                   sda_out;
    logic                   sda_oe;
    logic [1:0]             st;
    logic                   bus_active;
    logic                   wr_valid;
    logic                   wr_ready;
    i2cdw_pkg::i2cdw_word_t wr_data;
    i2cdw_pkg::i2cdw_word_t exp_q[$];
    int                     n_fail = 0;
    int                     checks_done = 0;

    // Pull-up data line: low whenever either party pulls it.
    wire sda = !(m_low || (sda_oe && !sda_out));

    i2cdw_master i_i2cdw_master (.scl(scl), .sda_low(m_low), .sda(sda));

    i2cdw_slave #(.FIFO_DEPTH(DEPTH)) i_i2cdw_slave (
        .sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .addr_strap_hi(st[1]), .addr_strap_lo(st[0]),
        .bus_active(bus_active), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data)
    );

    task automatic check_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic check_word(input i2cdw_pkg::i2cdw_word_t got,
                              input i2cdw_pkg::i2cdw_word_t exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Words are sampled mid-cycle, ahead of the edge that takes them.
    always @(negedge sys_clk)
    begin
        if (rst_b === 1'h1 && wr_valid === 1'h1 && wr_ready === 1'h1)
        begin
            if (exp_q.size() == 0)
                check_bit(1'h1, 1'h0);
            else
                check_word(wr_data, exp_q.pop_front());
        end
    end

    task automatic tx(input logic [7:0] b, input logic exp);
        logic a;
        i_i2cdw_master.send_byte(b, a);
        check_bit(a, exp);
    endtask

    task automatic open_frame(input logic exp);
        i_i2cdw_master.send_start();
        tx({`I2CDW_ADDR_FIXED, st, 1'h0}, exp);
    endtask

    // The word is expected before its low byte, as it can appear before the byte ends.
    task automatic word(input logic [7:0] ch, input logic bst, input logic [7:0] hi,
                        input logic [7:0] lo);
        tx(hi, 1'h1);
        exp_q.push_back({ch, bst, !bst, hi, lo});
        tx(lo, 1'h1);
    endtask

    // Bounded wait for the consumer side to take every expected word.
    task automatic drain();
        for (int i = 0; i < 60 && exp_q.size() > 0; i++)
            @(posedge sys_clk);
        check_bit(exp_q.size() == 0, 1'h1);
        @(posedge sys_clk);
        #1;
    endtask

    task automatic close();
        i_i2cdw_master.send_stop();
        repeat (3) @(posedge sys_clk);
        #1;
        check_bit(bus_active, 1'h0);
        drain();
    endtask

    task automatic t_four_byte();
        for (int s = 0; s < 4; s++)
        begin
            st = s[1:0];
            open_frame(1'h1);
            check_bit(bus_active, 1'h1);
            tx(8'(s + 5), 1'h1);
            word(8'(s + 5), 1'h0, {s[1:0], 6'h15}, 8'hA5 ^ 8'(s));
            close();
        end
    endtask

    task automatic t_three_byte();
        st = 2'h1;
        open_frame(1'h1);
        tx(8'h03, 1'h1);
        word(8'h03, 1'h0, 8'h40, 8'h01);
        tx(8'h07, 1'h1);
        word(8'h07, 1'h0, 8'h80, 8'hFF);
        tx(8'h09, 1'h1);
        tx(8'h12, 1'h1);
        close();
    endtask

    task automatic t_burst();
        st = 2'h2;
        open_frame(1'h1);
        tx(`I2CDW_BURST_PTR, 1'h1);
        for (int k = 0; k < 3; k++)
            word(8'(k), 1'h1, {k[1:0], 6'h3F}, 8'(k));
        open_frame(1'h1);
        check_bit(bus_active, 1'h1);
        tx(8'h02, 1'h1);
        word(8'h02, 1'h0, 8'hC0, 8'h00);
        close();
    endtask

    task automatic t_bad_addr();
        logic [7:0] bad [5] = '{8'hA8, 8'hAA, 8'hAC, 8'hAF, 8'hA6};
        st = 2'h3;
        for (int i = 0; i < 5; i++)
        begin
            i_i2cdw_master.send_start();
            tx(bad[i], 1'h0);
            tx(8'h55, 1'h0);
            close();
        end
    endtask

    // A stalled consumer fills the FIFO until the low byte is refused; the master retries.
    task automatic t_full();
        int n;
        logic a;
        st = 2'h0;
        wr_ready = 1'h0;
        open_frame(1'h1);
        n = 0;
        a = 1'h1;
        while (a === 1'h1 && n < 8)
        begin
            tx(8'(n), 1'h1);
            tx(8'h3C, 1'h1);
            i_i2cdw_master.send_byte(8'(n), a);
            if (a === 1'h1)
            begin
                exp_q.push_back({8'(n), 2'h1, 8'h3C, 8'(n)});
                n++;
            end
        end
        i_i2cdw_master.send_stop();
        @(posedge sys_clk);
        #1;
        wr_ready = 1'h1;
        drain();
        check_bit(n >= DEPTH && n <= DEPTH + 1, 1'h1);
        open_frame(1'h1);
        tx(8'(n), 1'h1);
        word(8'(n), 1'h0, 8'h3C, 8'(n));
        close();
    endtask

    initial
    begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end

    // The whole run needs about 30 us of bus traffic.
    initial
    begin
        #200000;
        n_fail++;
        tally_and_finish();
    end

    initial
    begin
        rst_b = 1'h0;
        st = 2'h0;
        wr_ready = 1'h1;
        repeat (3) @(posedge sys_clk);
        #1;
        rst_b = 1'h1;
        repeat (6) @(posedge sys_clk);
        #1;
        check_bit(bus_active, 1'h0);
        check_bit(wr_valid, 1'h0);
        check_bit(sda_oe, 1'h0);
        t_four_byte();
        t_three_byte();
        t_burst();
        t_bad_addr();
        t_full();
        tally_and_finish();
    end
endmodule
